// ---- rtl/mdscc_pkg.sv ----
// constants, state and carrier types of the serial configuration chain node
package mdscc_pkg;

  // data path
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int IMAGE_BYTES = 64;
  localparam int CNT_W = 32;
  localparam int TMR_W = 16;

  // clock and timing
  localparam int MCLK_PERIOD_NS = 5;
  localparam int STATUS_LOW_NS = 40;
  localparam int INIT_NS = 100;
  localparam int STATUS_LOW_CYCLES =
    (STATUS_LOW_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int INIT_CYCLES =
    (INIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // scheme_select encoding
  localparam logic SCHEME_ACTIVE = 1'b1;
  localparam logic SCHEME_PASSIVE = 1'b0;

  // pin synchroniser slots
  localparam int SYN_DONE = 0;
  localparam int SYN_STATUS = 1;
  localparam int SYN_SCHEME = 2;
  localparam int SYN_FLASH = 3;
  localparam int SYN_CE = 4;
  localparam int NUM_SYNC = 5;

  // reset values
  localparam logic [NUM_SYNC-1:0] SYNC_CHAIN_RST = 5'h00;
  localparam logic [NUM_SYNC-1:0] SYNC_FILT_RST = 5'h12;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [2:0] BITS_RST = 3'h0;
  localparam logic [2:0] BITS_LAST = 3'h7;

  typedef enum logic [2:0]
  {
    ST_RESET,
    ST_RELEASE,
    ST_LOAD,
    ST_WAIT_DONE,
    ST_INIT,
    ST_USER,
    ST_ERROR
  } mdscc_state_t;

  typedef struct packed
  {
    logic is_master;
    logic load_error;
    logic init_mode;
    logic user_mode;
  } mdscc_phase_t;

endpackage

// ---- rtl/mdscc_chain_node.sv ----
// chain node: serial receive, byte fifo, done/status handling, start-up
// Functional notes
// - first device, strapped active serial, masters chain; others are slaves
// - status and done are open-drain shared pins, driven low only
// - after own image, drive chain enable out and release done line
// - keep done line low until own image fully received
// - when done line reads high, enter initialization together
// - master takes first image copy; second copy passes on to slaves
// - master with flash loader design enters user mode despite done low

module mdscc_fifo #(
  parameter int WIDTH = mdscc_pkg::BYTE_W,
  parameter int DEPTH = mdscc_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } mdscc_fifo_st_t;

  mdscc_fifo_st_t f_q;
  mdscc_fifo_st_t f_d;
  logic push;
  logic pop;

  assign in_ready = (f_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (f_q.cnt != '0);
  assign out_data = f_q.mem[f_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    f_d = f_q;
    if (push)
    begin
      f_d.mem[f_q.wp] = in_data;
      if (f_q.wp == AW'(DEPTH - 1))
        f_d.wp = '0;
      else
        f_d.wp = AW'(f_q.wp + 1'b1);
    end
    if (pop)
    begin
      if (f_q.rp == AW'(DEPTH - 1))
        f_d.rp = '0;
      else
        f_d.rp = AW'(f_q.rp + 1'b1);
    end
    // simultaneous push and pop leaves the level unchanged
    if (push && !pop)
      f_d.cnt = (AW+1)'(f_q.cnt + 1'b1);
    else if (pop && !push)
      f_d.cnt = (AW+1)'(f_q.cnt - 1'b1);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      f_q <= '0;
    else
      f_q <= f_d;
  end
endmodule

module mdscc_chain_node #(
  parameter int IMAGE_BYTES = mdscc_pkg::IMAGE_BYTES,
  parameter int FIFO_DEPTH = mdscc_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic config_clock,
  input wire logic config_data,
  input wire logic chip_enable_in_n,
  input wire logic scheme_select,
  input wire logic flash_loader_design,
  input wire logic config_done_line_i,
  output logic config_done_line_o,
  output logic config_done_line_oe,
  input wire logic config_status_n_i,
  output logic config_status_n_o,
  output logic config_status_n_oe,
  output logic chain_enable_out_n,
  output logic [mdscc_pkg::BYTE_W-1:0] cfg_data,
  output logic cfg_valid,
  input wire logic cfg_ready,
  output mdscc_pkg::mdscc_phase_t phase
);

  // link side: runs only while the clock toggles during a frame
  typedef struct packed
  {
    logic [mdscc_pkg::BYTE_W-1:0] shift;
    logic [2:0] bits;
    logic [mdscc_pkg::BYTE_W-1:0] word;
    logic tog;
  } mdscc_link_st_t;

  typedef struct packed
  {
    mdscc_pkg::mdscc_state_t st;
    logic [mdscc_pkg::TMR_W-1:0] tmr;
    logic [mdscc_pkg::CNT_W-1:0] byte_cnt;
    logic [mdscc_pkg::NUM_SYNC-1:0] s1;
    logic [mdscc_pkg::NUM_SYNC-1:0] s2;
    logic [mdscc_pkg::NUM_SYNC-1:0] s3;
    logic [mdscc_pkg::NUM_SYNC-1:0] filt;
    logic tog_s1;
    logic tog_s2;
    logic tog_seen;
    logic hold_v;
    logic [mdscc_pkg::BYTE_W-1:0] hold_d;
    logic master;
    logic flash;
    logic done_rel;
    logic chain_en;
    logic status_drv;
    logic init_mode;
    logic user_mode;
    logic err;
  } mdscc_core_st_t;

  mdscc_link_st_t l_q;
  mdscc_link_st_t l_d;
  mdscc_core_st_t c_q;
  mdscc_core_st_t c_d;
  logic fifo_in_ready;
  logic byte_evt;
  logic push;
  logic [mdscc_pkg::NUM_SYNC-1:0] pins;
  logic [mdscc_pkg::CNT_W-1:0] next_cnt;

  // link domain: lsb-first deserialiser on rising config_clock
  always_comb
  begin
    l_d = l_q;
    if (!chip_enable_in_n)
    begin
      l_d.shift = {config_data, l_q.shift[mdscc_pkg::BYTE_W-1:1]};
      l_d.bits = 3'(l_q.bits + 1'b1);
      if (l_q.bits == mdscc_pkg::BITS_LAST)
      begin
        // word stays put for a whole byte time, long enough to cross
        l_d.word = {config_data, l_q.shift[mdscc_pkg::BYTE_W-1:1]};
        l_d.tog = !l_q.tog;
      end
    end
    else
    begin
      // a deselect drops any partial byte
      l_d.bits = mdscc_pkg::BITS_RST;
    end
  end

  always_ff @(posedge config_clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      l_q.shift <= mdscc_pkg::BYTE_RST;
      l_q.bits <= mdscc_pkg::BITS_RST;
      l_q.word <= mdscc_pkg::BYTE_RST;
      l_q.tog <= 1'b0;
    end
    else
      l_q <= l_d;
  end

  assign pins[mdscc_pkg::SYN_DONE] = config_done_line_i;
  assign pins[mdscc_pkg::SYN_STATUS] = config_status_n_i;
  assign pins[mdscc_pkg::SYN_SCHEME] = scheme_select;
  assign pins[mdscc_pkg::SYN_FLASH] = flash_loader_design;
  assign pins[mdscc_pkg::SYN_CE] = chip_enable_in_n;

  assign byte_evt = (c_q.tog_s2 != c_q.tog_seen);
  assign push = c_q.hold_v && fifo_in_ready;
  assign next_cnt = mdscc_pkg::CNT_W'(c_q.byte_cnt + 1'b1);

  // core domain
  always_comb
  begin
    c_d = c_q;
    c_d.s1 = pins;
    c_d.s2 = c_q.s1;
    c_d.s3 = c_q.s2;
    for (int i = 0; i < mdscc_pkg::NUM_SYNC; i++)
    begin
      // a pin level counts only once two late stages agree
      if (c_q.s2[i] == c_q.s3[i])
        c_d.filt[i] = c_q.s2[i];
    end
    c_d.tog_s1 = l_q.tog;
    c_d.tog_s2 = c_q.tog_s1;
    c_d.tog_seen = c_q.tog_s2;
    if (push)
      c_d.hold_v = 1'b0;

    case (c_q.st)
      mdscc_pkg::ST_RESET:
      begin
        c_d.status_drv = 1'b1;
        if (c_q.tmr == '0)
        begin
          c_d.status_drv = 1'b0;
          c_d.st = mdscc_pkg::ST_RELEASE;
        end
        else
          c_d.tmr = mdscc_pkg::TMR_W'(c_q.tmr - 1'b1);
      end
      mdscc_pkg::ST_RELEASE:
      begin
        // wait for every member to let go of the status line
        if (c_q.filt[mdscc_pkg::SYN_STATUS])
        begin
          c_d.master = (c_q.filt[mdscc_pkg::SYN_SCHEME] ==
            mdscc_pkg::SCHEME_ACTIVE);
          c_d.flash = c_q.filt[mdscc_pkg::SYN_FLASH];
          c_d.byte_cnt = '0;
          c_d.st = mdscc_pkg::ST_LOAD;
        end
      end
      mdscc_pkg::ST_LOAD:
      begin
        if (!c_q.filt[mdscc_pkg::SYN_STATUS])
        begin
          c_d.st = mdscc_pkg::ST_RESET;
          c_d.tmr = mdscc_pkg::TMR_W'(mdscc_pkg::STATUS_LOW_CYCLES);
        end
        else if (byte_evt && !c_q.filt[mdscc_pkg::SYN_CE])
        begin
          if (c_q.hold_v && !push)
          begin
            // serial stream cannot be paused, so a full path is fatal
            c_d.err = 1'b1;
            c_d.status_drv = 1'b1;
            c_d.st = mdscc_pkg::ST_ERROR;
          end
          else
          begin
            c_d.hold_v = 1'b1;
            c_d.hold_d = l_q.word;
            c_d.byte_cnt = next_cnt;
            if (next_cnt == mdscc_pkg::CNT_W'(IMAGE_BYTES))
            begin
              c_d.done_rel = 1'b1;
              c_d.chain_en = 1'b1;
              c_d.st = mdscc_pkg::ST_WAIT_DONE;
            end
          end
        end
      end
      mdscc_pkg::ST_WAIT_DONE:
      begin
        // later bytes are the next copy, meant for the slaves
        if (c_q.master && c_q.flash)
        begin
          c_d.user_mode = 1'b1;
          c_d.st = mdscc_pkg::ST_USER;
        end
        else if (!c_q.filt[mdscc_pkg::SYN_STATUS])
        begin
          c_d.done_rel = 1'b0;
          c_d.chain_en = 1'b0;
          c_d.st = mdscc_pkg::ST_RESET;
          c_d.tmr = mdscc_pkg::TMR_W'(mdscc_pkg::STATUS_LOW_CYCLES);
        end
        else if (c_q.filt[mdscc_pkg::SYN_DONE])
        begin
          c_d.init_mode = 1'b1;
          c_d.tmr = mdscc_pkg::TMR_W'(mdscc_pkg::INIT_CYCLES);
          c_d.st = mdscc_pkg::ST_INIT;
        end
      end
      mdscc_pkg::ST_INIT:
      begin
        if (c_q.tmr == '0)
        begin
          c_d.init_mode = 1'b0;
          c_d.user_mode = 1'b1;
          c_d.st = mdscc_pkg::ST_USER;
        end
        else
          c_d.tmr = mdscc_pkg::TMR_W'(c_q.tmr - 1'b1);
      end
      mdscc_pkg::ST_USER:
      begin
        c_d.user_mode = 1'b1;
      end
      mdscc_pkg::ST_ERROR:
      begin
        // held until reset; the whole chain sees status low
        c_d.status_drv = 1'b1;
        c_d.err = 1'b1;
      end
      default:
      begin
        c_d.st = mdscc_pkg::ST_ERROR;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      c_q.st <= mdscc_pkg::ST_RESET;
      c_q.tmr <= mdscc_pkg::TMR_W'(mdscc_pkg::STATUS_LOW_CYCLES);
      c_q.byte_cnt <= '0;
      c_q.s1 <= mdscc_pkg::SYNC_CHAIN_RST;
      c_q.s2 <= mdscc_pkg::SYNC_CHAIN_RST;
      c_q.s3 <= mdscc_pkg::SYNC_CHAIN_RST;
      c_q.filt <= mdscc_pkg::SYNC_FILT_RST;
      c_q.tog_s1 <= 1'b0;
      c_q.tog_s2 <= 1'b0;
      c_q.tog_seen <= 1'b0;
      c_q.hold_v <= 1'b0;
      c_q.hold_d <= mdscc_pkg::BYTE_RST;
      c_q.master <= 1'b0;
      c_q.flash <= 1'b0;
      c_q.done_rel <= 1'b0;
      c_q.chain_en <= 1'b0;
      c_q.status_drv <= 1'b1;
      c_q.init_mode <= 1'b0;
      c_q.user_mode <= 1'b0;
      c_q.err <= 1'b0;
    end
    else
      c_q <= c_d;
  end

  mdscc_fifo #(
    .WIDTH(mdscc_pkg::BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(c_q.hold_v),
    .in_ready(fifo_in_ready),
    .in_data(c_q.hold_d),
    .out_valid(cfg_valid),
    .out_ready(cfg_ready),
    .out_data(cfg_data)
  );

  // open-drain: only ever pull low, pull-ups make the high
  assign config_done_line_o = 1'b0;
  assign config_done_line_oe = !c_q.done_rel;
  assign config_status_n_o = 1'b0;
  assign config_status_n_oe = c_q.status_drv;
  assign chain_enable_out_n = !c_q.chain_en;
  assign phase.is_master = c_q.master;
  assign phase.load_error = c_q.err;
  assign phase.init_mode = c_q.init_mode;
  assign phase.user_mode = c_q.user_mode;

endmodule

// ---- verification/mdscc_mem_model.sv ----
// serial memory model driving the shared config clock and data line
module mdscc_mem_model (
  output logic config_clock,
  output logic config_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    config_clock = 1'b0;
    config_data = 1'b0;
  end
  // one memory, clock and data fanned out in parallel
  task automatic send_byte(input logic [7:0] b);
    #1.3;
    for (int i = 0; i < 8; i++)
    begin
      config_data = b[i];
      #80 config_clock = 1'b1;
      #80 config_clock = 1'b0;
    end
    // clock stands still; line shows no stale bit
    config_data = ~b[7];
  endtask
endmodule

// ---- verification/mdscc_checker.sv ----
// concurrent checks on the chain node ports
module mdscc_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scheme_select,
  input wire logic flash_loader_design,
  input wire logic config_done_line_i,
  input wire logic config_done_line_o,
  input wire logic config_done_line_oe,
  input wire logic config_status_n_o,
  input wire logic config_status_n_oe,
  input wire logic chain_enable_out_n,
  input wire logic [7:0] cfg_data,
  input wire logic cfg_valid,
  input wire logic cfg_ready,
  input mdscc_pkg::mdscc_phase_t phase
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  AST_PULL_ONLY: assert property
    (!config_done_line_o && !config_status_n_o)
    else $error("open drain pin driven high");
  AST_CEO_DONE: assert property
    ($fell(chain_enable_out_n) |-> !config_done_line_oe)
    else $error("done still pulled at hand-off");
  AST_DONE_HOLD: assert property
    ($fell(config_done_line_oe) |-> $fell(chain_enable_out_n))
    else $error("done released before image end");
  AST_DONE_PULLED: assert property
    (chain_enable_out_n |-> config_done_line_oe)
    else $error("done released while image incomplete");
  AST_INIT_SYNC: assert property
    ($rose(phase.init_mode) |-> $past(config_done_line_i, 2))
    else $error("init entered with done low");
  AST_INIT_LEN: assert property
    ($rose(phase.init_mode) |->
      ##[19:22] (phase.user_mode && !phase.init_mode))
    else $error("init length wrong");
  AST_USER_HOLD: assert property
    (phase.user_mode |=> phase.user_mode)
    else $error("user mode dropped");
  AST_FLASH_USER: assert property
    ($fell(chain_enable_out_n) && phase.is_master && flash_loader_design
      |-> ##[1:2] phase.user_mode)
    else $error("flash master not in user mode");
  AST_MASTER: assert property
    ($rose(phase.is_master) |-> scheme_select)
    else $error("master without active strap");
  AST_ERR_STATUS: assert property
    (phase.load_error |-> config_status_n_oe)
    else $error("error without status pull");
  AST_VALID_STANDS: assert property
    (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data))
    else $error("byte lost while stalled");
endmodule
bind mdscc_chain_node mdscc_checker u_mdscc_checker (
  .mclk(mclk), .rst_b(rst_b), .scheme_select(scheme_select),
  .flash_loader_design(flash_loader_design),
  .config_done_line_i(config_done_line_i),
  .config_done_line_o(config_done_line_o),
  .config_done_line_oe(config_done_line_oe),
  .config_status_n_o(config_status_n_o),
  .config_status_n_oe(config_status_n_oe),
  .chain_enable_out_n(chain_enable_out_n), .cfg_data(cfg_data),
  .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .phase(phase));

// ---- verification/mdscc_chain_node_test.sv ----
// self-checking bench for the chain node
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("BAD %0t got %h want %h", $time, g, e); \
    end \
  end
`define WAIT(c, n) \
  for (int k = 0; (c) !== 1'b1; k++) \
  begin \
    if (k == n) timeout(); \
    @(negedge mclk); \
  end
module mdscc_chain_node_test;
  timeunit 1ns;
  timeprecision 100ps;
  // one image size serves every identical slave
  localparam int IMG = 20;
  logic mclk, rst_b, ce_n, scheme, flash, other_pull, cfg_ready;
  logic cclk, cdata, done_o, done_oe, stat_o, stat_oe, ceo_n, cfg_valid;
  logic [7:0] cfg_data;
  mdscc_pkg::mdscc_phase_t phase;
  // shared lines with pull-ups; other_pull is a slower chain member
  wire done_w = !(done_oe || other_pull);
  wire stat_w = !stat_oe;
  int num_errors = 0;
  int total_checks = 0;
  mdscc_mem_model u_mdscc_mem_model (.config_clock(cclk),
    .config_data(cdata));
  mdscc_chain_node #(.IMAGE_BYTES(IMG),
    .FIFO_DEPTH(mdscc_pkg::FIFO_DEPTH)) u_mdscc_chain_node (
    .mclk(mclk), .rst_b(rst_b), .config_clock(cclk), .config_data(cdata),
    .chip_enable_in_n(ce_n), .scheme_select(scheme),
    .flash_loader_design(flash), .config_done_line_i(done_w),
    .config_done_line_o(done_o), .config_done_line_oe(done_oe),
    .config_status_n_i(stat_w), .config_status_n_o(stat_o),
    .config_status_n_oe(stat_oe), .chain_enable_out_n(ceo_n),
    .cfg_data(cfg_data), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
    .phase(phase));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    $display("BAD %0t wait ran out", $time);
    print_verdict();
  endtask
  task automatic do_reset(input logic s, input logic f);
    @(negedge mclk);
    rst_b = 1'b0;
    scheme = s;
    flash = f;
    other_pull = 1'b1;
    ce_n = 1'b0;
    cfg_ready = 1'b0;
    repeat (20) @(negedge mclk);
    `CHK(done_oe, 1'b1)
    `CHK(ceo_n, 1'b1)
    `CHK(cfg_valid, 1'b0)
    rst_b = 1'b1;
    repeat (20) @(negedge mclk);
    `CHK(phase.is_master, s)
  endtask
  task automatic pop_check(input logic [7:0] e);
    // back on the falling edge before touching the consumer handshake
    @(negedge mclk);
    `WAIT(cfg_valid, 40)
    `CHK(cfg_data, e)
    cfg_ready = 1'b1;
    @(negedge mclk);
    cfg_ready = 1'b0;
  endtask
  task automatic test_master();
    do_reset(1'b1, 1'b0);
    for (int i = 0; i < IMG; i++)
    begin
      u_mdscc_mem_model.send_byte(8'h3C ^ 8'(i * 7));
      pop_check(8'h3C ^ 8'(i * 7));
      if (i < IMG - 1)
        `CHK(done_oe, 1'b1)
    end
    repeat (10) @(negedge mclk);
    `CHK(ceo_n, 1'b0)
    `CHK(done_oe, 1'b0)
    repeat (50) @(negedge mclk);
    `CHK(phase.init_mode, 1'b0)
    other_pull = 1'b0;
    `WAIT(phase.init_mode, 10)
    `CHK(phase.user_mode, 1'b0)
    `WAIT(phase.user_mode, 30)
    // second copy belongs to the slaves
    u_mdscc_mem_model.send_byte(8'hA5);
    repeat (10) @(negedge mclk);
    `CHK(cfg_valid, 1'b0)
    $display("done master load");
  endtask
  task automatic test_flash();
    do_reset(1'b1, 1'b1);
    cfg_ready = 1'b1;
    for (int i = 0; i < IMG; i++)
      u_mdscc_mem_model.send_byte(8'h5A);
    `WAIT(phase.user_mode, 20)
    `CHK(done_w, 1'b0)
    `CHK(phase.init_mode, 1'b0)
    $display("done flash master");
  endtask
  task automatic test_slave_ce();
    do_reset(1'b0, 1'b0);
    ce_n = 1'b1;
    u_mdscc_mem_model.send_byte(8'hC3);
    repeat (10) @(negedge mclk);
    `CHK(cfg_valid, 1'b0)
    ce_n = 1'b0;
    u_mdscc_mem_model.send_byte(8'h96);
    pop_check(8'h96);
    $display("done slave enable");
  endtask
  task automatic test_fill();
    do_reset(1'b0, 1'b0);
    // fifo full plus holding stage; stream cannot stall
    for (int i = 0; i < 9; i++)
      u_mdscc_mem_model.send_byte(8'h10 + 8'(i));
    `CHK(phase.load_error, 1'b0)
    for (int i = 0; i < 9; i++)
      pop_check(8'h10 + 8'(i));
    `CHK(cfg_valid, 1'b0)
    for (int i = 0; i < 10; i++)
      u_mdscc_mem_model.send_byte(8'h80 + 8'(i));
    repeat (10) @(negedge mclk);
    `CHK(phase.load_error, 1'b1)
    `CHK(stat_oe, 1'b1)
    $display("done fifo fill");
  endtask
  initial
  begin
    rst_b = 1'b0;
    ce_n = 1'b0;
    scheme = 1'b1;
    flash = 1'b0;
    other_pull = 1'b1;
    cfg_ready = 1'b0;
    test_master();
    test_flash();
    test_slave_ce();
    test_fill();
    print_verdict();
  end
endmodule
